// [usw_top.sv]
// serial word interface of the asynchronous transceiver, with its engines
`timescale 1ns/1ps
`include "usw_cfg.svh"

// What this block does
// - read-back returns the active configuration on bits 13 to 0
// - bit 15 of every reply shows received data waiting
// - bit 14 of every reply shows transmit buffer empty
// - read-back bit 13 shows fifo disabled
// - read-back bit 12 shows shutdown state
// - bits 11 to 8 are the four interrupt enables
// - infrared mode bit selects pulse timing on the line
// - two_end_bits gives two stop bits, else one
// - parity_on adds a parity slot both ways
// - seven_bit_word gives 7 data bits, else 8
// - read-back with bit 0 set puts an 8x clock (16x tick halved) on rts while selected
// - bit 15 out at select fall, then msb first on sclk fall
// - inhibit set updates rts without queueing a byte, else byte is queued
// - rts request drives rts pin inverted
// - sent parity is send_parity_value; top data bit dropped in 7-bit
// - data replies: bits 13-11 zero, bit 10 activity or framing error
// - bit 9 reports inverted cts pin
// - bit 8 received parity, bits 7-0 received byte, bit 7 zero in 7-bit
// - rate generator divides oscillator to 16x bit rate for both engines
// - codes map to ratios 1..128 and 3..384, default code 0
// - interrupt holds while data waiting and its enable set
// - framing error set on zero stop bit, cleared by good character
// - data words clear interrupt unless its cause persists
module usw_top
(
  input  logic                    clk,
  input  logic                    resetn,
  input  logic                    osc_input,
  input  usw_pkg::usw_spi_in_type spi,
  input  logic                    rx,
  input  logic                    cts_n,
  output logic                    sdo,
  output logic                    tx,
  output logic                    rts_n,
  output logic                    irq_n
);
  import usw_pkg::*;

  typedef struct packed {
    logic [1:0]     cs_s;
    logic [1:0]     sclk_s;
    logic [1:0]     sdi_s;
    logic [1:0]     rx_s;
    logic [1:0]     cts_s;
    logic           cs_p;
    logic           sclk_p;
    logic           rx_p;
    logic [14:0]    sin;
    logic [15:0]    wd;
    logic [4:0]     cnt;
    logic           test;
    usw_config_type cfg;
    usw_config_type pend;
    logic           pend_v;
    logic           rts_req;
    logic           rts_clk;
    logic [7:0]     tbuf;
    logic           tpar;
    logic           tfull;
    logic           tbusy;
    logic [11:0]    tsh;
    logic [3:0]     tbits;
    logic [3:0]     ttick;
    logic           tev;
    logic           rbusy;
    logic [3:0]     rtick;
    logic [3:0]     rbits;
    logic [10:0]    rsh;
    logic [7:0]     rbyte;
    logic           rpar;
    logic           rfull;
    logic           fe;
    logic           act;
    logic           sdo;
    logic           tx;
    logic           rts_n;
    logic           irq_n;
  } usw_state_type;

  usw_state_type  s;
  usw_state_type  next_s;
  usw_config_type wcfg;
  logic           tick;
  logic           cs_low;
  logic           cs_fall;
  logic           sclk_rise;
  logic           sclk_fall;
  logic [15:0]    word;
  logic           exec;
  logic           taken;
  logic           afe;
  logic           tbit;
  logic           rxl;
  logic [3:0]     nd;
  logic [3:0]     tlen;
  logic [3:0]     rlen;
  logic [10:0]    al;
  logic [7:0]     rdata;

  usw_baud u_baud
  (
    .clk                 (clk),
    .resetn              (resetn),
    .osc_input           (osc_input),
    .rate_divisor_select (s.cfg.rate_divisor_select),
    .run                 (~s.cfg.shutdown_state),
    .tick                (tick)
  );

  // whole block state; order of blocks below sets priority
  always_comb
  begin
    next_s = s;
    exec = 1'b0;
    taken = 1'b0;
    wcfg = '0;
    al = '0;
    rdata = '0;
    // pin synchronisers, stage 0 feeds stage 1 only
    next_s.cs_s = {s.cs_s[0], spi.cs_n};
    next_s.sclk_s = {s.sclk_s[0], spi.sclk};
    next_s.sdi_s = {s.sdi_s[0], spi.sdi};
    next_s.rx_s = {s.rx_s[0], rx};
    next_s.cts_s = {s.cts_s[0], cts_n};
    next_s.cs_p = s.cs_s[1];
    next_s.sclk_p = s.sclk_s[1];
    next_s.rx_p = s.rx_s[1];
    cs_low = ~s.cs_s[1];
    cs_fall = s.cs_p & ~s.cs_s[1];
    sclk_rise = cs_low & ~s.sclk_p & s.sclk_s[1];
    sclk_fall = cs_low & s.sclk_p & ~s.sclk_s[1];
    word = {s.sin, s.sdi_s[1]};
    afe = s.cfg.shutdown_state ? s.act : s.fe;
    nd = s.cfg.seven_bit_word ? 4'h7 : 4'h8;
    tlen = 4'h2 + nd + {3'h0, s.cfg.parity_on}
           + {3'h0, s.cfg.two_end_bits};
    rlen = 4'h2 + nd + {3'h0, s.cfg.parity_on};
    rxl = s.cfg.infrared_mode ? ~s.rx_s[1] : s.rx_s[1];

    // pending configuration waits for the transmitter to drain
    if (s.pend_v && !s.tfull && !s.tbusy)
    begin
      next_s.cfg = s.pend;
      next_s.pend_v = 1'b0;
      if (s.pend.shutdown_state != s.cfg.shutdown_state)
      begin
        next_s.act = 1'b0;
        next_s.rfull = 1'b0;
        next_s.fe = 1'b0;
        next_s.rbusy = 1'b0;
        next_s.rbyte = 8'h00;
        next_s.rpar = 1'b0;
        next_s.tpar = 1'b0;
      end
    end

    // transmitter takes the buffered character
    if (s.tfull && !s.tbusy && !s.pend_v && !s.cfg.shutdown_state)
    begin
      next_s.tsh = s.cfg.seven_bit_word ?
        {3'h7, s.tpar | ~s.cfg.parity_on, s.tbuf[6:0], 1'b0} :
        {2'h3, s.tpar | ~s.cfg.parity_on, s.tbuf, 1'b0};
      next_s.tbits = tlen;
      next_s.ttick = 4'h0;
      next_s.tbusy = 1'b1;
      next_s.tfull = 1'b0;
      taken = 1'b1;
    end
    else if (s.tbusy && tick)
    begin
      next_s.ttick = s.ttick + 4'h1;
      if (s.ttick == `USW_OSR_LAST)
      begin
        next_s.tsh = {1'b1, s.tsh[11:1]};
        next_s.tbits = s.tbits - 4'h1;
        next_s.tbusy = (s.tbits != 4'h1);
      end
    end

    // serial word: capture on rise, present on fall
    if (!cs_low)
    begin
      next_s.test = 1'b0;
    end
    if (cs_fall)
    begin
      next_s.cnt = 5'h00;
      next_s.wd = {s.rfull, ~s.tfull, 14'h0000};
      next_s.sdo = s.rfull;
    end
    if (sclk_rise && s.cnt < `USW_WORD_BITS)
    begin
      next_s.sin = word[14:0];
      next_s.cnt = s.cnt + 5'h01;
      if (s.cnt == `USW_OP_KNOWN)
      begin
        unique case (word[1:0])
          `USW_OP_RCFG:  next_s.wd[13:0] = s.cfg;
          `USW_OP_WCFG:  next_s.wd[13:0] = 14'h0000;
          default:
            next_s.wd[13:0] = {3'h0, afe, ~s.cts_s[1], s.rpar,
                               s.rbyte};
        endcase
      end
      exec = (s.cnt == `USW_WORD_LAST);
    end
    if (sclk_fall && s.cnt < `USW_WORD_BITS)
    begin
      next_s.sdo = s.wd[4'hf - s.cnt[3:0]];
    end

    // command acts only once the sixteenth bit is in
    if (exec)
    begin
      unique case (word[15:14])
        `USW_OP_RCFG:
          next_s.test = word[`USW_BIT_TEST];
        `USW_OP_WCFG:
        begin
          wcfg = word[13:0];
          next_s.pend = wcfg;
          next_s.pend_v = 1'b1;
          // masks act at once, the rest after transmission
          next_s.cfg.send_empty_int_enable = wcfg.send_empty_int_enable;
          next_s.cfg.data_ready_int_enable = wcfg.data_ready_int_enable;
          next_s.cfg.parity_high_int_enable = wcfg.parity_high_int_enable;
          next_s.cfg.activity_int_enable = wcfg.activity_int_enable;
          next_s.rfull = 1'b0;
          next_s.fe = 1'b0;
          next_s.act = 1'b0;
          next_s.rbyte = 8'h00;
          next_s.rpar = 1'b0;
          next_s.tpar = 1'b0;
        end
        `USW_OP_WDATA:
        begin
          next_s.rts_req = word[`USW_BIT_RTS];
          next_s.rfull = 1'b0;
          next_s.tev = 1'b0;
          if (!word[`USW_BIT_INHIB])
          begin
            next_s.tbuf = word[7:0];
            next_s.tpar = word[`USW_BIT_PAR];
            next_s.tfull = 1'b1;
          end
        end
        `USW_OP_RDATA:
        begin
          next_s.rfull = 1'b0;
          next_s.tev = 1'b0;
        end
      endcase
    end
    // buffer emptying set wins over the clear above
    next_s.tev = next_s.tev | taken;

    // receiver: start found on a tick, sampled at mid bit
    if (s.cfg.shutdown_state)
    begin
      if (s.rx_s[1] != s.rx_p)
      begin
        next_s.act = 1'b1;
      end
    end
    else if (!s.rbusy)
    begin
      if (tick && !rxl)
      begin
        next_s.rbusy = 1'b1;
        next_s.rtick = 4'h0;
        next_s.rbits = 4'h0;
      end
    end
    else if (tick)
    begin
      next_s.rtick = s.rtick + 4'h1;
      if (s.rtick == `USW_OSR_MID)
      begin
        next_s.rsh = {rxl, s.rsh[10:1]};
        next_s.rbits = s.rbits + 4'h1;
        if (s.rbits == 4'h0 && rxl)
        begin
          next_s.rbusy = 1'b0; // glitch, not a start bit
        end
        else if (s.rbits + 4'h1 == rlen)
        begin
          next_s.rbusy = 1'b0;
          al = next_s.rsh >> (`USW_RX_LEN - rlen);
          rdata = s.cfg.seven_bit_word ? {1'b0, al[7:1]} : al[8:1];
          if (al[rlen - 4'h1])
          begin
            next_s.fe = 1'b0;
            next_s.rbyte = rdata;
            next_s.rpar = s.cfg.parity_on & al[nd + 4'h1];
            next_s.rfull = 1'b1;
          end
          else
          begin
            next_s.fe = 1'b1;
          end
        end
      end
    end

    // pin outputs, all registered
    if (tick)
    begin
      next_s.rts_clk = ~s.rts_clk;
    end
    tbit = s.tbusy ? s.tsh[0] : 1'b1;
    if (s.test && cs_low)
    begin
      next_s.rts_n = s.rts_clk;
      next_s.tx = 1'b0;
    end
    else
    begin
      next_s.rts_n = ~s.rts_req;
      // infrared: short high pulse for each zero, low when idle
      next_s.tx = s.cfg.infrared_mode ?
        (~tbit & s.tbusy & (s.ttick < `USW_IR_PULSE)) : tbit;
    end
    next_s.irq_n = ~((s.cfg.send_empty_int_enable & s.tev)
                   | (s.cfg.data_ready_int_enable & s.rfull)
                   | (s.cfg.parity_high_int_enable & s.rfull & s.rpar)
                   | (s.cfg.activity_int_enable & afe));
  end

  // reset leaves pins idle: tx high, rts high, no interrupt
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.cs_s <= 2'h3;
      s.cs_p <= 1'b1;
      // line idles high: avoids a false start bit right after reset
      s.rx_s <= 2'h3;
      s.rx_p <= 1'b1;
      s.cfg <= `USW_CFG_RESET;
      s.pend <= `USW_CFG_RESET;
      s.tx <= 1'b1;
      s.rts_n <= 1'b1;
      s.irq_n <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sdo = s.sdo;
  assign tx = s.tx;
  assign rts_n = s.rts_n;
  assign irq_n = s.irq_n;

endmodule

// [usw_cfg.svh]
// constants for the serial word interface: opcodes, bit spots, timing
`ifndef USW_CFG_SVH
`define USW_CFG_SVH

// command codes carried in the top two bits of a word
`define USW_OP_RDATA   2'b00
`define USW_OP_RCFG    2'b01
`define USW_OP_WDATA   2'b10
`define USW_OP_WCFG    2'b11

// word framing
`define USW_WORD_LAST  5'd15
`define USW_WORD_BITS  5'd16
`define USW_OP_KNOWN   5'd1
`define USW_BIT_TEST   0
`define USW_BIT_INHIB  10
`define USW_BIT_RTS    9
`define USW_BIT_PAR    8

// oversampling: sixteen ticks of the rate clock per bit
`define USW_OSR_LAST   4'hf
`define USW_OSR_MID    4'h7
`define USW_IR_PULSE   4'h3

// divide ratio bases: codes 0xxx use 1, codes 1xxx use 3
`define USW_RATIO_EVEN 9'h001
`define USW_RATIO_ODD  9'h003

// configuration after reset: fifo on, running, masks off, 8n1, ratio 1
`define USW_CFG_RESET  14'h0000

// receive shift register length (start, 8 data, parity, stop)
`define USW_RX_LEN     4'hb

`endif

// [usw_pkg.sv]
// types shared by the serial word interface modules
package usw_pkg;

  // configuration as written and read back, bits 13 down to 0
  typedef struct packed {
    logic       fifo_disable;
    logic       shutdown_state;
    logic       send_empty_int_enable;
    logic       data_ready_int_enable;
    logic       parity_high_int_enable;
    logic       activity_int_enable;
    logic       infrared_mode;
    logic       two_end_bits;
    logic       parity_on;
    logic       seven_bit_word;
    logic [3:0] rate_divisor_select;
  } usw_config_type;

  // serial port pins from the host
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } usw_spi_in_type;

  // rate generator state
  typedef struct packed {
    logic [1:0] osc_s;
    logic       osc_p;
    logic [8:0] cnt;
    logic       tick;
  } usw_baud_state_type;

endpackage

// [usw_baud.sv]
// rate generator: divides the oscillator pin into a 16x bit-rate enable
`timescale 1ns/1ps
module usw_baud
(
  input  logic       clk,
  input  logic       resetn,
  input  logic       osc_input,
  input  logic [3:0] rate_divisor_select,
  input  logic       run,
  output logic       tick
);
  import usw_pkg::*;

  usw_baud_state_type s;
  usw_baud_state_type next_s;
  logic [8:0]         ratio;
  logic               osc_edge;

  // ratio table: base 1 or 3 shifted by the low three code bits
  always_comb
  begin
    next_s = s;
    ratio = (rate_divisor_select[3] ? `USW_RATIO_ODD : `USW_RATIO_EVEN)
            << rate_divisor_select[2:0];
    next_s.osc_s = {s.osc_s[0], osc_input};
    next_s.osc_p = s.osc_s[1];
    osc_edge = s.osc_s[1] & ~s.osc_p;
    next_s.tick = 1'b0;
    // stopped in shutdown so the engines freeze, as the oscillator would
    if (!run)
    begin
      next_s.cnt = 9'h000;
    end
    else if (osc_edge)
    begin
      if (s.cnt >= ratio - 9'h001)
      begin
        next_s.cnt = 9'h000;
        next_s.tick = 1'b1;
      end
      else
      begin
        next_s.cnt = s.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

// [usw_props.sv]
// pin-level assertions for the serial word interface
`timescale 1ns/1ps
module usw_props
(
  input logic                    clk,
  input logic                    resetn,
  input logic                    osc_input,
  input usw_pkg::usw_spi_in_type spi,
  input logic                    rx,
  input logic                    cts_n,
  input logic                    sdo,
  input logic                    tx,
  input logic                    rts_n,
  input logic                    irq_n
);
  import usw_pkg::*;
  logic [3:0]  cs_hi;
  logic [2:0]  ev;
  logic        ck_q;
  logic        cs_q;
  logic [15:0] sr;
  logic [4:0]  nb;
  logic        tst;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // pin trackers; the design sees pins two flops later
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_hi <= 4'h0;
      ev    <= 3'h7;
      ck_q  <= 1'b0;
      cs_q  <= 1'b1;
      sr    <= 16'h0000;
      nb    <= 5'h00;
      tst   <= 1'b0;
    end
    else
    begin
      cs_hi <= !spi.cs_n ? 4'h0 : cs_hi + {3'h0, cs_hi != 4'hf};
      ev    <= ((ck_q && !spi.sclk) || (cs_q && !spi.cs_n)) ? 3'h0
               : ev + {2'h0, ev != 3'h7};
      ck_q  <= spi.sclk;
      cs_q  <= spi.cs_n;
      nb    <= spi.cs_n ? 5'h00
               : nb + {4'h0, !ck_q && spi.sclk && nb != 5'h10};
      sr    <= (!ck_q && spi.sclk) ? {sr[14:0], spi.sdi} : sr;
      tst   <= !spi.cs_n && (tst || (nb == 5'h10 && sr == 16'h4001));
    end
  end

  // select low and clock high: no shift edge in flight
  sequence s_clk_high;
    (!spi.cs_n && spi.sclk) [*3];
  endsequence
  sequence s_test_held;
    tst [*6];
  endsequence

  chk_reset_values: assert property (
    $rose(resetn) |-> tx && rts_n && irq_n && !sdo)
    else $error("outputs not at reset levels");
  chk_sdo_idle: assert property (
    cs_hi >= 4'h6 |-> $stable(sdo))
    else $error("serial out moved while deselected");
  chk_sdo_clk_high: assert property (
    s_clk_high |-> $stable(sdo))
    else $error("serial out moved while clock high");
  chk_sdo_fall_lag: assert property (
    $changed(sdo) |-> ev inside {[3'h1:3'h4]})
    else $error("serial out moved away from a falling edge");
  chk_rts_quiet: assert property (
    cs_hi >= 4'h8 |-> $stable(rts_n))
    else $error("rts moved with no command");
  chk_tx_pace: assert property (
    $changed(tx) |=> $stable(tx))
    else $error("tx moved on two cycles in a row");
  chk_irq_pace: assert property (
    $changed(irq_n) |=> $stable(irq_n))
    else $error("interrupt glitched");
  chk_test_tx_low: assert property (
    s_test_held |-> !tx)
    else $error("tx not low in test mode");
endmodule

// [usw_host.sv]
// host model: bus master shifting 16-bit words
`timescale 1ns/1ps
module usw_host
(
  input  logic                    clk,
  input  logic                    sdo,
  output usw_pkg::usw_spi_in_type spi
);
  import usw_pkg::*;
  initial spi = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // one word msb first; hold keeps select low afterwards
  task automatic xfer(input logic [15:0] d, output logic [15:0] r,
                      input bit hold);
    w(1);
    spi.cs_n = 1'b0;
    w(5);
    for (int i = 15; i >= 0; i--)
    begin
      r[i] = sdo;
      spi.sdi = d[i];
      w(4);
      spi.sclk = 1'b1;
      w(4);
      spi.sclk = 1'b0;
      w(5);
    end
    if (!hold)
      rel();
  endtask

  // released data line shows no stale bit
  task automatic rel();
    spi.cs_n = 1'b1;
    spi.sdi = ~spi.sdi;
    w(5);
  endtask
endmodule

// [uart_spi_word_interface_tb_top.sv]
// testbench: host words, serial line stimulus, checks
`timescale 1ns/1ps
module uart_spi_word_interface_tb_top;
  import usw_pkg::*;
  logic           clk = 1'b0;
  logic           resetn = 1'b0;
  logic           osc_input = 1'b0;
  logic           rx = 1'b1;
  logic           cts_n = 1'b1;
  usw_spi_in_type spi;
  logic           sdo, tx, rts_n, irq_n;
  logic [15:0]    r;
  logic [10:0]    t;
  int             k;
  int             bad_count = 0;
  int             n_checks = 0;

  // 10 MHz clock; 2.5 MHz oscillator, changing on falling clock edges
  always #50 clk = ~clk;
  always #200 osc_input = ~osc_input;

  usw_top i_dut (.clk(clk), .resetn(resetn), .osc_input(osc_input),
    .spi(spi), .rx(rx), .cts_n(cts_n), .sdo(sdo), .tx(tx),
    .rts_n(rts_n), .irq_n(irq_n));
  usw_host i_host (.clk(clk), .sdo(sdo), .spi(spi));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input logic [15:0] m);
    n_checks++;
    if ((g & m) !== (e & m))
    begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic word(input logic [15:0] d, input logic [15:0] e,
                      input logic [15:0] m);
    i_host.xfer(d, r, 1'b0);
    chk(r, e, m);
  endtask

  // character on rx lsb first; ratio 1 gives 64 clocks a bit
  task automatic rxs(input logic [10:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx = b[i];
      cyc(64);
    end
    rx = 1'b1;
    cyc(64);
  endtask

  // sample 11 bits after a start bit, mid bit
  task automatic txcap(output logic [10:0] v);
    k = 0;
    while (tx !== 1'b0 && k < 2000)
    begin
      cyc(1);
      k++;
    end
    cyc(32);
    for (int i = 0; i < 11; i++)
    begin
      cyc(64);
      v[i] = tx;
    end
  endtask

  // clocks between two rts edges; first edge only aligns
  task automatic per(output int p);
    logic q;
    int   j;
    q = rts_n;
    j = 0;
    while (rts_n === q && j < 4000)
    begin
      cyc(1);
      j++;
    end
    q = rts_n;
    p = 0;
    while (rts_n === q && p < 4000)
    begin
      cyc(1);
      p++;
    end
  endtask

  initial
  begin
    cyc(12);
    resetn = 1'b1;
    cyc(4);
    word(16'h4000, 16'h4000, 16'hffff);
    chk({15'h0, rts_n}, 16'h1, 16'h1);
    word(16'he460, 16'h4000, 16'hffff);
    word(16'h4000, 16'h6460, 16'hffff);
    $display("done: configuration");
    cts_n = 1'b0;
    word(16'h83a5, 16'h4200, 16'hffff);
    chk({15'h0, rts_n}, 16'h0, 16'h1);
    txcap(t);
    chk({5'h0, t}, {5'h0, 3'b111, 8'ha5}, 16'h07ff);
    word(16'h825a, 16'h4200, 16'hffff);
    word(16'h8266, 16'h4200, 16'hffff);
    word(16'h0000, 16'h0200, 16'hfe00);
    cyc(1600);
    word(16'h8400, 16'h4200, 16'hfe00);
    chk({15'h0, rts_n}, 16'h1, 16'h1);
    k = 0;
    repeat (300)
    begin
      cyc(1);
      if (tx !== 1'b1)
        k++;
    end
    chk(k[15:0], 16'h0, 16'hffff);
    $display("done: transmit");
    cts_n = 1'b1;
    rxs({2'b11, 8'h3c, 1'b0}, 11);
    chk({15'h0, irq_n}, 16'h0, 16'h1);
    word(16'h0000, 16'hc13c, 16'hffff);
    chk({15'h0, irq_n}, 16'h1, 16'h1);
    word(16'h0000, 16'h4000, 16'hc000);
    rxs({2'b00, 8'h55, 1'b0}, 11);
    word(16'h0000, 16'h4400, 16'hfe00);
    rxs({2'b10, 8'h81, 1'b0}, 11);
    word(16'h0000, 16'hc081, 16'hffff);
    word(16'hc010, 16'h4000, 16'hc000);
    word(16'h80aa, 16'h4000, 16'hc000);
    txcap(t);
    chk({5'h0, t}, 16'h07aa, 16'h07ff);
    rxs({3'b111, 7'h7f, 1'b0}, 9);
    word(16'h0000, 16'hc07f, 16'hfeff);
    $display("done: receive");
    for (int c = 0; c < 16; c++)
    begin
      word(16'hc000 | 16'(c), 16'h4000, 16'hc000);
      i_host.xfer(16'h4001, r, 1'b1);
      chk(r, 16'h4000 | 16'(c), 16'hffff);
      chk({15'h0, tx}, 16'h0, 16'h1);
      per(k);
      chk(k[15:0], 16'(4 * ((c[3] ? 3 : 1) << c[2:0])), 16'hffff);
      i_host.rel();
    end
    $display("done: rate and test mode");
    end_of_test();
  end

  // hang guard: the tests need about 21k to 25k cycles
  initial
  begin
    #8000000;
    bad_count++;
    end_of_test();
  end
endmodule

bind usw_top usw_props i_props (.clk(clk), .resetn(resetn),
  .osc_input(osc_input), .spi(spi), .rx(rx), .cts_n(cts_n),
  .sdo(sdo), .tx(tx), .rts_n(rts_n), .irq_n(irq_n));
